// >>> test/instr_decoder_properties.sv
// Concurrent checks on the ports of the instruction decoder.
// Assumes it is bound to instr_decoder and sees only that module's ports.
`timescale 1ns/1ps
module instr_decoder_properties
  import decoder_pkg::*;
#(
  parameter logic [6:0] TIMER_FILE = TIMER_FILE_DEF
) (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic [12:0] pc_in,
  input wire logic        prescaler_on_timer_in,
  input wire logic        issue_out,
  input wire logic        nop_slot_out,
  input wire op_e         op_out,
  input wire logic [6:0]  file_addr_out,
  input wire logic [2:0]  bit_sel_out,
  input wire logic [7:0]  bit_mask_out,
  input wire logic        upd_carry_out,
  input wire logic        upd_zero_out,
  input wire logic        upd_expiry_sleep_out,
  input wire logic        two_cycle_out,
  input wire logic        pc_load_out,
  input wire logic        stack_push_out,
  input wire logic [12:0] push_pc_out,
  input wire logic        watchdog_kick_out,
  input wire logic        prescaler_clear_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  issue_gap_a: assert property (issue_out |=> !issue_out [*3])
    else $error("issue pulses closer than one instruction cycle");
  issue_rate_a: assert property (issue_out |-> ##4 issue_out)
    else $error("instruction cycle not four clocks long");
  field_hold_a: assert property (issue_out |=> $stable(file_addr_out) [*3])
    else $error("file address changed within an instruction cycle");
  bit_mask_a: assert property (issue_out |-> bit_mask_out == 8'h01 << bit_sel_out)
    else $error("bit mask does not match bit position");
  call_push_a: assert property (issue_out && op_out == OP_CALL_SUB |->
    stack_push_out && pc_load_out && push_pc_out == $past(pc_in) + 13'h0001)
    else $error("call did not push the next address");
  flow_kill_a: assert property (issue_out && two_cycle_out |->
    ##4 (issue_out && nop_slot_out && op_out == OP_NO_OPERATION))
    else $error("slot after a jump was not a no-op");
  rotate_flag_a: assert property (issue_out && op_out inside {OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY} |-> upd_carry_out && !upd_zero_out)
    else $error("rotate updates wrong flags");
  kick_flag_a: assert property (watchdog_kick_out |->
    issue_out && upd_expiry_sleep_out && op_out == OP_WATCHDOG_KICK)
    else $error("watchdog kick without its flags");
  nop_quiet_a: assert property (nop_slot_out |->
    issue_out && !pc_load_out && !stack_push_out && !upd_zero_out && !upd_carry_out)
    else $error("forced no-op changed state");
  prescale_clr_a: assert property (prescaler_clear_out |-> issue_out &&
    file_addr_out == TIMER_FILE && $past(prescaler_on_timer_in))
    else $error("prescaler cleared without cause");
endmodule

bind instr_decoder instr_decoder_properties #(.TIMER_FILE(TIMER_FILE)) u_props (
  .clk_sys_in, .sys_rst_in, .pc_in, .prescaler_on_timer_in, .issue_out, .nop_slot_out,
  .op_out, .file_addr_out, .bit_sel_out, .bit_mask_out, .upd_carry_out, .upd_zero_out,
  .upd_expiry_sleep_out, .two_cycle_out, .pc_load_out, .stack_push_out, .push_pc_out,
  .watchdog_kick_out, .prescaler_clear_out
);

// >>> test/prog_mem_model.sv
// Program memory fetch model presenting one word and its address per cycle.
// Assumes the bench supplies the next word and the issue pulse advances it.
`timescale 1ns/1ps
module prog_mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        issue_in,
  input  wire logic [13:0] next_word_in,
  output logic      [13:0] word_out,
  output logic      [12:0] pc_out
);
  // Loads a new word after each issue, so one word per instruction cycle.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      word_out <= 14'h0000;
      pc_out   <= 13'h0000;
    end else if (issue_in) begin
      word_out <= next_word_in;
      pc_out   <= pc_out + 13'h0001;
    end
  end
endmodule

// >>> test/test_instr_decoder.sv
// Self-checking bench of the instruction decoder against a reference model.
// Assumes the program memory model feeds words and the checker is bound.
`timescale 1ns/1ps
module test_instr_decoder;
  import decoder_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        instr_valid_in = 1'b1;
  logic        result_zero_in = 1'b0;
  logic        tested_bit_in = 1'b0;
  logic        prescaler_on_timer_in = 1'b0;
  logic [13:0] next_word = 14'h2005;
  logic [13:0] instr_word_in, w;
  logic [12:0] pc_in, push_pc_out;
  logic [6:0]  file_addr_out;
  logic [2:0]  bit_sel_out;
  logic [7:0]  bit_mask_out, literal_out;
  logic [10:0] target_out, fx;
  logic [11:0] got;
  logic        issue_out, nop_slot_out, dest_file_out, upd_carry_out, upd_half_carry_flag_out;
  logic        upd_zero_out, upd_expiry_sleep_out, skip_test_out, two_cycle_out, pc_load_out;
  logic        stack_push_out, stack_pop_out, watchdog_kick_out, standby_out, read_pins_out;
  logic        prescaler_clear_out, kill;
  logic [31:0] rnd = 32'h37EA94DF;
  op_e         op_out, e;
  int          n_errors = 0, checked = 0, n_iss = 0, cyc = 0, pend = 0;
  logic [13:0] dq[$] = '{14'h3F12, 14'h0785, 14'h0709, 14'h0789, 14'h078A, 14'h2FFF, 14'h0000,
    14'h0008, 14'h0001, 14'h0009, 14'h3100, 14'h3455, 14'h0060, 14'h3B00, 14'h0064, 14'h0063,
    14'h0001, 14'h0B81, 14'h1A85, 14'h1E05, 14'h3E01, 14'h3F01, 14'h3C01, 14'h3D01, 14'h3801,
    14'h3901, 14'h3A01, 14'h0181, 14'h1401, 14'h0081, 14'h1081};
  op_e         yo[16] = '{OP_NO_OPERATION, OP_NO_OPERATION, OP_SUB_W_FROM_FILE, OP_DECREMENT,
    OP_OR_W_FILE, OP_AND_W_FILE, OP_XOR_W_FILE, OP_ADD_W_TO_FILE, OP_MOVE_FILE, OP_COMPLEMENT,
    OP_INCREMENT, OP_DECREMENT_SKIP_ZERO, OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY,
    OP_SWAP_NIBBLES, OP_INCREMENT_SKIP_ZERO};
  op_e         bo[4] = '{OP_BIT_CLEAR, OP_BIT_SET, OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET};

  prog_mem_model pm (
    .clk_sys_in, .sys_rst_in, .issue_in(issue_out), .next_word_in(next_word),
    .word_out(instr_word_in), .pc_out(pc_in)
  );
  instr_decoder dut (
    .clk_sys_in, .sys_rst_in, .instr_word_in, .instr_valid_in, .pc_in, .result_zero_in,
    .tested_bit_in, .prescaler_on_timer_in, .issue_out, .nop_slot_out, .op_out,
    .file_addr_out, .dest_file_out, .bit_sel_out, .bit_mask_out, .literal_out, .target_out,
    .upd_carry_out, .upd_half_carry_flag_out, .upd_zero_out, .upd_expiry_sleep_out,
    .skip_test_out, .two_cycle_out, .pc_load_out, .stack_push_out, .stack_pop_out,
    .push_pc_out, .watchdog_kick_out, .standby_out, .read_pins_out, .prescaler_clear_out
  );

  always #12.5 clk_sys_in = ~clk_sys_in;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic op_e eop(input logic [13:0] v);
    casez (v)
      14'b00_0000_0??0_0000: return OP_NO_OPERATION;
      14'h0008: return OP_SUBROUTINE_RETURN;
      14'h0009: return OP_INTERRUPT_RETURN;
      14'h0063: return OP_STANDBY_ENTER;
      14'h0064: return OP_WATCHDOG_KICK;
      14'b00_0000_1???_????: return OP_MOVE_W_TO_FILE;
      14'b00_0001_0???_????: return OP_CLEAR_W;
      14'b00_0001_1???_????: return OP_CLEAR_FILE;
      14'b00_????_????_????: return yo[v[11:8]];
      14'b01_????_????_????: return bo[v[11:10]];
      14'b10_????_????_????: return v[11] ? OP_JUMP_ABSOLUTE : OP_CALL_SUB;
      14'b11_00??_????_????: return OP_LOAD_LITERAL;
      14'b11_01??_????_????: return OP_RETURN_WITH_LITERAL;
      14'b11_1000_????_????: return OP_OR_LITERAL;
      14'b11_1001_????_????: return OP_AND_LITERAL;
      14'b11_1010_????_????: return OP_XOR_LITERAL;
      14'b11_110?_????_????: return OP_LITERAL_MINUS_W;
      14'b11_111?_????_????: return OP_ADD_LITERAL;
      default: return OP_NO_OPERATION;
    endcase
  endfunction

  // Expected flag and control bits of one issued operation.
  function automatic logic [10:0] fl(input op_e o);
    logic ar, fw;
    ar = o inside {OP_ADD_W_TO_FILE, OP_SUB_W_FROM_FILE, OP_LITERAL_MINUS_W, OP_ADD_LITERAL};
    fw = o inside {OP_CALL_SUB, OP_JUMP_ABSOLUTE, OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN,
      OP_RETURN_WITH_LITERAL};
    return {ar | o inside {OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY}, ar,
      ar | o inside {OP_AND_W_FILE, OP_OR_W_FILE, OP_XOR_W_FILE, OP_CLEAR_W, OP_CLEAR_FILE,
      OP_COMPLEMENT, OP_DECREMENT, OP_INCREMENT, OP_MOVE_FILE, OP_OR_LITERAL, OP_AND_LITERAL,
      OP_XOR_LITERAL}, o inside {OP_WATCHDOG_KICK, OP_STANDBY_ENTER},
      o inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO, OP_TEST_SKIP_IF_CLEAR,
      OP_TEST_SKIP_IF_SET}, fw, o inside {OP_CALL_SUB, OP_JUMP_ABSOLUTE}, o == OP_CALL_SUB,
      fw & o != OP_CALL_SUB & o != OP_JUMP_ABSOLUTE, o == OP_WATCHDOG_KICK,
      o == OP_STANDBY_ENTER};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares every issued slot with the model and feeds the next word.
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pend = 0;
    end else if (issue_out) begin
      w = instr_word_in;
      kill = pend == 1 || (pend == 2 && result_zero_in) || (pend == 3 && !tested_bit_in)
        || (pend == 4 && tested_bit_in);
      e = (kill || !instr_valid_in) ? OP_NO_OPERATION : eop(w);
      fx = fl(e);
      got = {nop_slot_out, upd_carry_out, upd_half_carry_flag_out, upd_zero_out,
        upd_expiry_sleep_out, skip_test_out, two_cycle_out, pc_load_out, stack_push_out,
        stack_pop_out, watchdog_kick_out, standby_out};
      check(op_out, e);
      check(got, {kill, fx});
      if (instr_valid_in) begin
        check({file_addr_out, bit_sel_out, bit_mask_out},
          {w[6:0], w[9:7], 8'h01 << w[9:7]});
        check({literal_out, target_out}, {w[7:0], w[10:0]});
      end
      if (e != OP_NO_OPERATION && w[13:12] == 2'h0 && w[11:9] != 3'h0) begin
        check(dest_file_out, w[7]);
        check(read_pins_out, w[7] && w[6:0] >= PORT_FIRST_DEF
          && w[6:0] <= PORT_LAST_DEF);
      end else begin
        check({dest_file_out, read_pins_out}, {e inside {OP_MOVE_W_TO_FILE, OP_CLEAR_FILE,
          OP_BIT_CLEAR, OP_BIT_SET}, 1'b0});
      end
      check(prescaler_clear_out, e != OP_NO_OPERATION && prescaler_on_timer_in
        && w[6:0] == TIMER_FILE_DEF && (w[13:12] == 2'h0 ? w[7] : w[13:12] == 2'h1 && !w[11]));
      if (e == OP_CALL_SUB)
        check(push_pc_out, pc_in + 13'h0001);
      pend = fx[6] ? (e == OP_TEST_SKIP_IF_CLEAR ? 3 : e == OP_TEST_SKIP_IF_SET ? 4 : 2)
        : fx[5] ? 1 : 0;
      n_iss++;
      rnd = xs(rnd);
      next_word <= (dq.size() != 0) ? dq.pop_front() : rnd[13:0];
      instr_valid_in <= pend != 0 || rnd[18:16] != 3'h0;
      result_zero_in <= rnd[20];
      tested_bit_in <= rnd[21];
      prescaler_on_timer_in <= rnd[22];
    end
  end

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wait (n_iss >= 300);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wait (n_iss >= 700);
    tally_and_finish();
  end
endmodule

// >>> verilog/cycle_phase_gen.sv
// Instruction-cycle enable generator: one pulse every PERIODS oscillator clocks.
// Assumes the system clock is the core oscillator.
`timescale 1ns/1ps
module cycle_phase_gen
  import decoder_pkg::*;
#(
  parameter int PERIODS = CYCLE_OSC_PERIODS
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  output logic      cycle_en_out
);

  localparam int CW = (PERIODS > 2) ? $clog2(PERIODS) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIODS - 1);

  logic [CW-1:0] phase_r;

  generate
    if (PERIODS < 2) begin : g_bad
      $error("PERIODS must be at least 2");
    end
  endgenerate

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_r <= '0;
    end else if (phase_r == LAST) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cycle_en_out <= 1'b0;
    end else begin
      cycle_en_out <= (phase_r == CW'(PERIODS - 2));
    end
  end

endmodule

// >>> verilog/decoder_pkg.sv
// Shared constants, opcode patterns and types of the 14-bit instruction decoder.
// Assumes one system clock; the instruction cycle is a divided enable.
package decoder_pkg;

  localparam int CYCLE_OSC_PERIODS = 4;
  localparam int PC_W              = 13;
  localparam int WORD_W            = 14;
  localparam int FILE_W            = 7;
  localparam int BIT_W             = 3;
  localparam int LIT_W             = 8;
  localparam int TGT_W             = 11;
  localparam int FILE_LSB          = 0;
  localparam int DEST_POS          = 7;
  localparam int BIT_LSB           = 7;
  localparam int LIT_LSB           = 0;
  localparam int TGT_LSB           = 0;

  localparam logic [6:0] TIMER_FILE_DEF = 7'h01;
  localparam logic [6:0] PORT_FIRST_DEF = 7'h05;
  localparam logic [6:0] PORT_LAST_DEF  = 7'h09;

  localparam logic [13:0] PAT_NO_OPERATION      = 14'b00_0000_0??0_0000;
  localparam logic [13:0] PAT_SUBROUTINE_RETURN = 14'b00_0000_0000_1000;
  localparam logic [13:0] PAT_INTERRUPT_RETURN  = 14'b00_0000_0000_1001;
  localparam logic [13:0] PAT_WATCHDOG_KICK     = 14'b00_0000_0110_0100;
  localparam logic [13:0] PAT_STANDBY_ENTER     = 14'b00_0000_0110_0011;
  localparam logic [13:0] PAT_MOVE_W_TO_FILE    = 14'b00_0000_1???_????;
  localparam logic [13:0] PAT_CLEAR_W           = 14'b00_0001_0???_????;
  localparam logic [13:0] PAT_CLEAR_FILE        = 14'b00_0001_1???_????;
  localparam logic [13:0] PAT_SUB_W_FROM_FILE   = 14'b00_0010_????_????;
  localparam logic [13:0] PAT_DECREMENT         = 14'b00_0011_????_????;
  localparam logic [13:0] PAT_OR_W_FILE         = 14'b00_0100_????_????;
  localparam logic [13:0] PAT_AND_W_FILE        = 14'b00_0101_????_????;
  localparam logic [13:0] PAT_XOR_W_FILE        = 14'b00_0110_????_????;
  localparam logic [13:0] PAT_ADD_W_TO_FILE     = 14'b00_0111_????_????;
  localparam logic [13:0] PAT_MOVE_FILE         = 14'b00_1000_????_????;
  localparam logic [13:0] PAT_COMPLEMENT        = 14'b00_1001_????_????;
  localparam logic [13:0] PAT_INCREMENT         = 14'b00_1010_????_????;
  localparam logic [13:0] PAT_DECREMENT_SKIP    = 14'b00_1011_????_????;
  localparam logic [13:0] PAT_ROTATE_RIGHT      = 14'b00_1100_????_????;
  localparam logic [13:0] PAT_ROTATE_LEFT       = 14'b00_1101_????_????;
  localparam logic [13:0] PAT_SWAP_NIBBLES      = 14'b00_1110_????_????;
  localparam logic [13:0] PAT_INCREMENT_SKIP    = 14'b00_1111_????_????;
  localparam logic [13:0] PAT_BIT_CLEAR         = 14'b01_00??_????_????;
  localparam logic [13:0] PAT_BIT_SET           = 14'b01_01??_????_????;
  localparam logic [13:0] PAT_TEST_SKIP_CLEAR   = 14'b01_10??_????_????;
  localparam logic [13:0] PAT_TEST_SKIP_SET     = 14'b01_11??_????_????;
  localparam logic [13:0] PAT_CALL_SUB          = 14'b10_0???_????_????;
  localparam logic [13:0] PAT_JUMP_ABSOLUTE     = 14'b10_1???_????_????;
  localparam logic [13:0] PAT_LOAD_LITERAL      = 14'b11_00??_????_????;
  localparam logic [13:0] PAT_RETURN_LITERAL    = 14'b11_01??_????_????;
  localparam logic [13:0] PAT_OR_LITERAL        = 14'b11_1000_????_????;
  localparam logic [13:0] PAT_AND_LITERAL       = 14'b11_1001_????_????;
  localparam logic [13:0] PAT_XOR_LITERAL       = 14'b11_1010_????_????;
  localparam logic [13:0] PAT_LITERAL_MINUS_W   = 14'b11_110?_????_????;
  localparam logic [13:0] PAT_ADD_LITERAL       = 14'b11_111?_????_????;

  typedef enum logic [5:0] {
    OP_NO_OPERATION, OP_MOVE_W_TO_FILE, OP_CLEAR_W, OP_CLEAR_FILE, OP_SUB_W_FROM_FILE,
    OP_DECREMENT, OP_OR_W_FILE, OP_AND_W_FILE, OP_XOR_W_FILE, OP_ADD_W_TO_FILE,
    OP_MOVE_FILE, OP_COMPLEMENT, OP_INCREMENT, OP_DECREMENT_SKIP_ZERO,
    OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY, OP_SWAP_NIBBLES, OP_INCREMENT_SKIP_ZERO,
    OP_BIT_CLEAR, OP_BIT_SET, OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET,
    OP_CALL_SUB, OP_JUMP_ABSOLUTE, OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN,
    OP_RETURN_WITH_LITERAL, OP_LOAD_LITERAL, OP_OR_LITERAL, OP_AND_LITERAL,
    OP_XOR_LITERAL, OP_LITERAL_MINUS_W, OP_ADD_LITERAL, OP_WATCHDOG_KICK,
    OP_STANDBY_ENTER
  } op_e;

  typedef enum logic [1:0] {
    SKIP_NONE, SKIP_ON_ZERO, SKIP_ON_CLEAR, SKIP_ON_SET
  } skip_e;

endpackage

// >>> verilog/instr_decoder.sv
// Decoder for 14-bit instruction words into operation, operands and cycle control.
// Assumes program memory and datapath run on clk_sys_in; no inputs need synchronising.
`timescale 1ns/1ps
module instr_decoder
  import decoder_pkg::*;
#(
  parameter int         PERIODS     = CYCLE_OSC_PERIODS,
  parameter logic [6:0] TIMER_FILE  = TIMER_FILE_DEF,
  parameter logic [6:0] PORT_FIRST  = PORT_FIRST_DEF,
  parameter logic [6:0] PORT_LAST   = PORT_LAST_DEF
) (
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  input  wire logic [WORD_W-1:0] instr_word_in,
  input  wire logic              instr_valid_in,
  input  wire logic [PC_W-1:0]   pc_in,
  input  wire logic              result_zero_in,
  input  wire logic              tested_bit_in,
  input  wire logic              prescaler_on_timer_in,
  output logic                   issue_out,
  output logic                   nop_slot_out,
  output op_e                    op_out,
  output logic [FILE_W-1:0]      file_addr_out,
  output logic                   dest_file_out,
  output logic [BIT_W-1:0]       bit_sel_out,
  output logic [7:0]             bit_mask_out,
  output logic [LIT_W-1:0]       literal_out,
  output logic [TGT_W-1:0]       target_out,
  output logic                   upd_carry_out,
  output logic                   upd_half_carry_flag_out,
  output logic                   upd_zero_out,
  output logic                   upd_expiry_sleep_out,
  output logic                   skip_test_out,
  output logic                   two_cycle_out,
  output logic                   pc_load_out,
  output logic                   stack_push_out,
  output logic                   stack_pop_out,
  output logic [PC_W-1:0]        push_pc_out,
  output logic                   watchdog_kick_out,
  output logic                   standby_out,
  output logic                   read_pins_out,
  output logic                   prescaler_clear_out
);

  generate
    if (PORT_FIRST > PORT_LAST) begin : g_bad_port
      $error("PORT_FIRST must not exceed PORT_LAST");
    end
  endgenerate

  logic  cycle_en;
  logic  flush_r;
  skip_e skip_r;
  logic  kill_c;
  logic  take_c;

  op_e   dec_op;
  logic  dec_c;
  logic  dec_dc;
  logic  dec_z;
  logic  dec_tp;
  logic  dec_two;
  logic  dec_jump;
  logic  dec_push;
  logic  dec_pop;
  logic  dec_wr_file;
  logic  dec_rmw;
  skip_e dec_skip;
  logic  dec_dest;
  logic  port_hit;
  logic  timer_hit;

  logic [FILE_W-1:0] f_field;
  logic [BIT_W-1:0]  b_field;
  logic [7:0]        mask_c;

  cycle_phase_gen #(
    .PERIODS (PERIODS)
  ) u_phase (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .cycle_en_out (cycle_en)
  );

  assign f_field   = instr_word_in[FILE_LSB +: FILE_W];
  assign b_field   = instr_word_in[BIT_LSB +: BIT_W];
  assign port_hit  = (f_field >= PORT_FIRST) && (f_field <= PORT_LAST);
  assign timer_hit = (f_field == TIMER_FILE);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      assign mask_c[gi] = (b_field == BIT_W'(gi));
    end
  endgenerate

  always_comb begin
    dec_op      = OP_NO_OPERATION;
    dec_c       = 1'b0;
    dec_dc      = 1'b0;
    dec_z       = 1'b0;
    dec_tp      = 1'b0;
    dec_jump    = 1'b0;
    dec_push    = 1'b0;
    dec_pop     = 1'b0;
    dec_rmw     = 1'b0;
    dec_skip    = SKIP_NONE;
    dec_dest    = instr_word_in[DEST_POS];
    dec_wr_file = 1'b0;
    casez (instr_word_in)
      PAT_NO_OPERATION: begin
        dec_op = OP_NO_OPERATION;
      end
      PAT_SUBROUTINE_RETURN: begin
        dec_op  = OP_SUBROUTINE_RETURN;
        dec_pop = 1'b1;
      end
      PAT_INTERRUPT_RETURN: begin
        dec_op  = OP_INTERRUPT_RETURN;
        dec_pop = 1'b1;
      end
      PAT_WATCHDOG_KICK: begin
        dec_op = OP_WATCHDOG_KICK;
        dec_tp = 1'b1;
      end
      PAT_STANDBY_ENTER: begin
        dec_op = OP_STANDBY_ENTER;
        dec_tp = 1'b1;
      end
      PAT_MOVE_W_TO_FILE: begin
        dec_op      = OP_MOVE_W_TO_FILE;
        dec_wr_file = 1'b1;
      end
      PAT_CLEAR_W: begin
        dec_op = OP_CLEAR_W;
        dec_z  = 1'b1;
      end
      PAT_CLEAR_FILE: begin
        dec_op      = OP_CLEAR_FILE;
        dec_z       = 1'b1;
        dec_wr_file = 1'b1;
      end
      PAT_SUB_W_FROM_FILE: begin
        dec_op = OP_SUB_W_FROM_FILE;
        {dec_c, dec_dc, dec_z} = 3'h7;
        dec_rmw = 1'b1;
      end
      PAT_ADD_W_TO_FILE: begin
        dec_op = OP_ADD_W_TO_FILE;
        {dec_c, dec_dc, dec_z} = 3'h7;
        dec_rmw = 1'b1;
      end
      PAT_OR_W_FILE: begin
        dec_op  = OP_OR_W_FILE;
        dec_z   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_AND_W_FILE: begin
        dec_op  = OP_AND_W_FILE;
        dec_z   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_XOR_W_FILE: begin
        dec_op  = OP_XOR_W_FILE;
        dec_z   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_ROTATE_LEFT: begin
        dec_op  = OP_ROTATE_LEFT_CARRY;
        dec_c   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_ROTATE_RIGHT: begin
        dec_op  = OP_ROTATE_RIGHT_CARRY;
        dec_c   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_DECREMENT_SKIP: begin
        dec_op   = OP_DECREMENT_SKIP_ZERO;
        dec_skip = SKIP_ON_ZERO;
        dec_rmw  = 1'b1;
      end
      PAT_INCREMENT_SKIP: begin
        dec_op   = OP_INCREMENT_SKIP_ZERO;
        dec_skip = SKIP_ON_ZERO;
        dec_rmw  = 1'b1;
      end
      PAT_DECREMENT: begin
        dec_op  = OP_DECREMENT;
        dec_z   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_INCREMENT: begin
        dec_op  = OP_INCREMENT;
        dec_z   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_MOVE_FILE: begin
        dec_op  = OP_MOVE_FILE;
        dec_z   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_COMPLEMENT: begin
        dec_op  = OP_COMPLEMENT;
        dec_z   = 1'b1;
        dec_rmw = 1'b1;
      end
      PAT_SWAP_NIBBLES: begin
        dec_op  = OP_SWAP_NIBBLES;
        dec_rmw = 1'b1;
      end
      PAT_BIT_CLEAR: begin
        dec_op      = OP_BIT_CLEAR;
        dec_wr_file = 1'b1;
      end
      PAT_BIT_SET: begin
        dec_op      = OP_BIT_SET;
        dec_wr_file = 1'b1;
      end
      PAT_TEST_SKIP_CLEAR: begin
        dec_op   = OP_TEST_SKIP_IF_CLEAR;
        dec_skip = SKIP_ON_CLEAR;
      end
      PAT_TEST_SKIP_SET: begin
        dec_op   = OP_TEST_SKIP_IF_SET;
        dec_skip = SKIP_ON_SET;
      end
      PAT_CALL_SUB: begin
        dec_op   = OP_CALL_SUB;
        dec_jump = 1'b1;
        dec_push = 1'b1;
      end
      PAT_JUMP_ABSOLUTE: begin
        dec_op   = OP_JUMP_ABSOLUTE;
        dec_jump = 1'b1;
      end
      PAT_LOAD_LITERAL: begin
        dec_op = OP_LOAD_LITERAL;
      end
      PAT_RETURN_LITERAL: begin
        dec_op  = OP_RETURN_WITH_LITERAL;
        dec_pop = 1'b1;
      end
      PAT_OR_LITERAL: begin
        dec_op = OP_OR_LITERAL;
        dec_z  = 1'b1;
      end
      PAT_AND_LITERAL: begin
        dec_op = OP_AND_LITERAL;
        dec_z  = 1'b1;
      end
      PAT_XOR_LITERAL: begin
        dec_op = OP_XOR_LITERAL;
        dec_z  = 1'b1;
      end
      PAT_LITERAL_MINUS_W: begin
        dec_op = OP_LITERAL_MINUS_W;
        {dec_c, dec_dc, dec_z} = 3'h7;
      end
      PAT_ADD_LITERAL: begin
        dec_op = OP_ADD_LITERAL;
        {dec_c, dec_dc, dec_z} = 3'h7;
      end
      default: begin
        dec_op = OP_NO_OPERATION;
      end
    endcase
    if (dec_rmw) begin
      dec_wr_file = dec_dest;
    end else begin
      dec_dest = dec_wr_file;
    end
    dec_two = dec_jump | dec_pop;
  end

  // A slot is killed when the previous instruction changed the counter or its test came true.
  always_comb begin
    unique case (skip_r)
      SKIP_NONE:     kill_c = flush_r;
      SKIP_ON_ZERO:  kill_c = flush_r | result_zero_in;
      SKIP_ON_CLEAR: kill_c = flush_r | ~tested_bit_in;
      SKIP_ON_SET:   kill_c = flush_r | tested_bit_in;
    endcase
  end

  assign take_c = cycle_en & ~kill_c & instr_valid_in;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flush_r <= 1'b0;
      skip_r  <= SKIP_NONE;
    end else if (cycle_en) begin
      flush_r <= take_c & dec_two;
      skip_r  <= take_c ? dec_skip : SKIP_NONE;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      issue_out    <= 1'b0;
      nop_slot_out <= 1'b0;
    end else begin
      issue_out    <= cycle_en;
      nop_slot_out <= cycle_en & kill_c;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      op_out                  <= OP_NO_OPERATION;
      file_addr_out           <= '0;
      dest_file_out           <= 1'b0;
      bit_sel_out             <= '0;
      bit_mask_out            <= '0;
      literal_out             <= '0;
      target_out              <= '0;
      upd_carry_out           <= 1'b0;
      upd_half_carry_flag_out <= 1'b0;
      upd_zero_out            <= 1'b0;
      upd_expiry_sleep_out    <= 1'b0;
      skip_test_out           <= 1'b0;
      two_cycle_out           <= 1'b0;
    end else if (cycle_en) begin
      op_out                  <= take_c ? dec_op : OP_NO_OPERATION;
      file_addr_out           <= f_field;
      dest_file_out           <= take_c & dec_dest;
      bit_sel_out             <= b_field;
      bit_mask_out            <= mask_c;
      literal_out             <= instr_word_in[LIT_LSB +: LIT_W];
      target_out              <= instr_word_in[TGT_LSB +: TGT_W];
      upd_carry_out           <= take_c & dec_c;
      upd_half_carry_flag_out <= take_c & dec_dc;
      upd_zero_out            <= take_c & dec_z;
      upd_expiry_sleep_out    <= take_c & dec_tp;
      skip_test_out           <= take_c & (dec_skip != SKIP_NONE);
      two_cycle_out           <= take_c & dec_two;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_load_out    <= 1'b0;
      stack_push_out <= 1'b0;
      stack_pop_out  <= 1'b0;
      push_pc_out    <= '0;
    end else begin
      pc_load_out    <= take_c & dec_jump;
      stack_push_out <= take_c & dec_push;
      stack_pop_out  <= take_c & dec_pop;
      if (take_c & dec_push) begin
        push_pc_out <= pc_in + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      watchdog_kick_out   <= 1'b0;
      standby_out         <= 1'b0;
      read_pins_out       <= 1'b0;
      prescaler_clear_out <= 1'b0;
    end else begin
      watchdog_kick_out   <= take_c & (dec_op == OP_WATCHDOG_KICK);
      standby_out         <= take_c & (dec_op == OP_STANDBY_ENTER);
      read_pins_out       <= take_c & dec_rmw & dec_wr_file & port_hit;
      prescaler_clear_out <= take_c & dec_wr_file & timer_hit & prescaler_on_timer_in;
    end
  end

endmodule
